// ### verilog/cmp_defs.vh
`ifndef CMP_DEFS_VH
`define CMP_DEFS_VH

// Compare operation encodings on cmp_op_in.
`define CMP_OP_SIGNED_REG 2'h0
`define CMP_OP_SIGNED_IMM 2'h1
`define CMP_OP_UNSIGNED_REG 2'h2
`define CMP_OP_UNSIGNED_IMM 2'h3

// Bit positions inside one 4-bit condition field.
`define FIELD_LESS_BIT 0
`define FIELD_GREATER_BIT 1
`define FIELD_EQUAL_BIT 2
`define FIELD_SO_BIT 3
`define FIELD_BITS 4

// Register byte offsets on the APB bus.
`define REG_COND_BITS 12'h000
`define REG_CONTROL 12'h004
`define REG_STATUS 12'h008
`define REG_COUNT 12'h00C

// Control register fields and reset value.
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 32'h0000_0001

// Status register fields.
`define STAT_INVALID_BIT 0
`define STAT_DONE_BIT 1
`define STAT_FIELD_LSB 4
`define STAT_FIELD_MSB 6

`define COND_RESET 32'h0000_0000
`define WORD_ZERO 32'h0000_0000

`endif

// ### verilog/magnitude_compare.v
`timescale 1ns/10ps
module magnitude_compare #(
  parameter WIDTH = 32
) (
  input wire [WIDTH-1:0] first_in,
  input wire [WIDTH-1:0] second_in,
  input wire signed_mode_in,
  output wire less_out,
  output wire greater_out,
  output wire equal_out
);

  // One extra top bit carries the sign in signed mode and zero otherwise, so a
  // single signed comparator serves both orderings.
  wire signed [WIDTH:0] first_ext;
  wire signed [WIDTH:0] second_ext;

  assign first_ext = {signed_mode_in & first_in[WIDTH-1], first_in};
  assign second_ext = {signed_mode_in & second_in[WIDTH-1], second_in};
  assign less_out = first_ext < second_ext;
  assign greater_out = first_ext > second_ext;
  assign equal_out = first_in == second_in;

endmodule

// ### verilog/integer_compare_unit.v
// What this block does
// - Signed register compare of source_gpr_one with source_gpr_two into the chosen field.
// - Signed immediate compare uses the sign-extended immediate against source_gpr_one.
// - Unsigned register compare of source_gpr_one with source_gpr_two into the chosen field.
// - Unsigned immediate compare prefixes sixteen zero bits to the immediate.
// - Field gets less, greater or equal flag plus current summary overflow copy.
// - Wide select zero means 32-bit compare; wide select one is an invalid form.
// - A compare rewrites all four bits of only the addressed field.
// - Field n holds less bit 4n, greater 4n+1, equal 4n+2, overflow 4n+3.
`timescale 1ns/10ps
`include "cmp_defs.vh"
module integer_compare_unit #(
  parameter WIDTH = 32,
  parameter IMM_WIDTH = 16,
  parameter FIELDS = 8,
  parameter FIELD_SEL_WIDTH = 3
) (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire cmp_valid_in,
  input wire [1:0] cmp_op_in,
  input wire [FIELD_SEL_WIDTH-1:0] target_condition_field_in,
  input wire wide_operand_select_in,
  input wire [WIDTH-1:0] source_gpr_one_in,
  input wire [WIDTH-1:0] source_gpr_two_in,
  input wire [IMM_WIDTH-1:0] immediate_in,
  input wire summary_overflow_in,
  output reg [FIELDS*4-1:0] condition_bits_register_out,
  output reg cmp_done_out,
  output reg cmp_invalid_out
);

  reg [31:0] control;
  reg invalid_seen;
  reg done_seen;
  reg [FIELD_SEL_WIDTH-1:0] last_field;
  reg [31:0] compare_count;

  wire [WIDTH-1:0] signed_imm_ext;
  wire [WIDTH-1:0] unsigned_imm_ext;
  reg [WIDTH-1:0] second_operand;
  reg signed_mode;
  wire less;
  wire greater;
  wire equal;
  wire [3:0] field_result;
  wire unit_enabled;
  wire do_compare;
  wire do_invalid;

  wire setup_phase;
  wire access_write;
  wire addr_mapped;
  reg [31:0] read_value;
  wire [FIELDS*4-1:0] cond_after_bus;
  wire [FIELDS*4-1:0] next_cond;
  wire next_invalid_seen;
  wire next_done_seen;

  assign signed_imm_ext = {{(WIDTH-IMM_WIDTH){immediate_in[IMM_WIDTH-1]}}, immediate_in};
  assign unsigned_imm_ext = {{(WIDTH-IMM_WIDTH){1'b0}}, immediate_in};

  always @*
  begin
    second_operand = source_gpr_two_in;
    signed_mode = 1'b1;
    case (cmp_op_in)
      `CMP_OP_SIGNED_REG:
      begin
        second_operand = source_gpr_two_in;
        signed_mode = 1'b1;
      end
      `CMP_OP_SIGNED_IMM:
      begin
        second_operand = signed_imm_ext;
        signed_mode = 1'b1;
      end
      `CMP_OP_UNSIGNED_REG:
      begin
        second_operand = source_gpr_two_in;
        signed_mode = 1'b0;
      end
      `CMP_OP_UNSIGNED_IMM:
      begin
        second_operand = unsigned_imm_ext;
        signed_mode = 1'b0;
      end
      default:
      begin
        second_operand = source_gpr_two_in;
        signed_mode = 1'b1;
      end
    endcase
  end

  magnitude_compare #(
    .WIDTH(WIDTH)
  ) u_magnitude_compare (
    .first_in(source_gpr_one_in),
    .second_in(second_operand),
    .signed_mode_in(signed_mode),
    .less_out(less),
    .greater_out(greater),
    .equal_out(equal)
  );

  // Exactly one of less, greater and equal is set; the overflow copy is the
  // live value at the compare, not a stored one.
  assign field_result[`FIELD_LESS_BIT] = less;
  assign field_result[`FIELD_GREATER_BIT] = greater;
  assign field_result[`FIELD_EQUAL_BIT] = equal;
  assign field_result[`FIELD_SO_BIT] = summary_overflow_in;

  assign unit_enabled = control[`CTRL_ENABLE_BIT];
  // A wide form never touches the condition bits; it only raises the invalid flag.
  assign do_compare = cmp_valid_in & unit_enabled & ~wide_operand_select_in;
  assign do_invalid = cmp_valid_in & unit_enabled & wide_operand_select_in;

  assign setup_phase = psel_in & ~penable_in;
  assign access_write = psel_in & penable_in & pwrite_in & pready_out & ~pslverr_out;
  assign addr_mapped = (paddr_in == `REG_COND_BITS) || (paddr_in == `REG_CONTROL) ||
                       (paddr_in == `REG_STATUS) || (paddr_in == `REG_COUNT);

  // A bus write lands first and a compare in the same cycle then overwrites its
  // own field, so the hardware result is never lost.
  assign cond_after_bus = (access_write && paddr_in == `REG_COND_BITS) ?
                          pwdata_in[FIELDS*4-1:0] : condition_bits_register_out;

  genvar fld;
  generate
    for (fld = 0; fld < FIELDS; fld = fld + 1)
    begin : g_field
      assign next_cond[fld*4 +: 4] =
        (do_compare && target_condition_field_in == fld) ?
        field_result : cond_after_bus[fld*4 +: 4];
    end
  endgenerate

  // Write one clears the sticky flags, but a new event in the same cycle wins.
  assign next_invalid_seen = do_invalid |
    (invalid_seen & ~(access_write && paddr_in == `REG_STATUS &&
                      pwdata_in[`STAT_INVALID_BIT]));
  assign next_done_seen = do_compare |
    (done_seen & ~(access_write && paddr_in == `REG_STATUS &&
                   pwdata_in[`STAT_DONE_BIT]));

  always @*
  begin
    read_value = `WORD_ZERO;
    case (paddr_in)
      `REG_COND_BITS:
      begin
        read_value[FIELDS*4-1:0] = condition_bits_register_out;
      end
      `REG_CONTROL:
      begin
        read_value = control;
      end
      `REG_STATUS:
      begin
        read_value[`STAT_INVALID_BIT] = invalid_seen;
        read_value[`STAT_DONE_BIT] = done_seen;
        read_value[`STAT_FIELD_MSB:`STAT_FIELD_LSB] = last_field;
      end
      `REG_COUNT:
      begin
        read_value = compare_count;
      end
      default:
      begin
        read_value = `WORD_ZERO;
      end
    endcase
  end

  // The slave answers in the first access cycle: pready is raised at the end of
  // setup and dropped after one cycle, which keeps every output registered.
  always @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= `WORD_ZERO;
    end
    else
    begin
      pready_out <= setup_phase;
      pslverr_out <= setup_phase & ~addr_mapped;
      if (setup_phase && !pwrite_in)
      begin
        prdata_out <= read_value;
      end
      else if (!psel_in)
      begin
        prdata_out <= `WORD_ZERO;
      end
    end
  end

  always @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      control <= `CTRL_RESET;
      condition_bits_register_out <= `COND_RESET;
      invalid_seen <= 1'b0;
      done_seen <= 1'b0;
      last_field <= {FIELD_SEL_WIDTH{1'b0}};
      compare_count <= `WORD_ZERO;
      cmp_done_out <= 1'b0;
      cmp_invalid_out <= 1'b0;
    end
    else
    begin
      if (access_write && paddr_in == `REG_CONTROL)
      begin
        control <= pwdata_in & `CTRL_RESET;
      end
      condition_bits_register_out <= next_cond;
      invalid_seen <= next_invalid_seen;
      done_seen <= next_done_seen;
      cmp_done_out <= do_compare;
      cmp_invalid_out <= do_invalid;
      if (do_compare)
      begin
        last_field <= target_condition_field_in;
        compare_count <= compare_count + 32'h0000_0001;
      end
      else if (access_write && paddr_in == `REG_COUNT)
      begin
        compare_count <= `WORD_ZERO;
      end
    end
  end

endmodule

// ### tb/cmp_properties.sv
`timescale 1ns/10ps
module cmp_checker (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic cmp_valid_in,
  input wire logic [1:0] cmp_op_in,
  input wire logic [2:0] target_condition_field_in,
  input wire logic wide_operand_select_in,
  input wire logic [31:0] source_gpr_one_in,
  input wire logic [31:0] source_gpr_two_in,
  input wire logic [15:0] immediate_in,
  input wire logic summary_overflow_in,
  input wire logic [31:0] condition_bits_register_out,
  input wire logic cmp_done_out,
  input wire logic cmp_invalid_out
);
  logic [31:0] y;
  logic [3:0] e;
  logic en;
  wire [31:0] a = source_gpr_one_in;
  wire [31:0] cnd = condition_bits_register_out;
  wire [4:0] sh = {target_condition_field_in, 2'h0};
  always_comb
  begin
    y = cmp_op_in[1] ? {16'h0000, immediate_in} : {{16{immediate_in[15]}}, immediate_in};
    y = cmp_op_in[0] ? y : source_gpr_two_in;
    e[0] = cmp_op_in[1] ? a < y : $signed(a) < $signed(y);
    e[1] = cmp_op_in[1] ? a > y : $signed(a) > $signed(y);
    e[2] = a == y;
    e[3] = summary_overflow_in;
  end
  // A disabled unit ignores requests, so the checker keeps its own copy of the enable bit.
  always @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
      en <= 1'b1;
    else if (psel_in && penable_in && pwrite_in && pready_out && !pslverr_out &&
             paddr_in == 12'h004)
      en <= pwdata_in[0];
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_go;
    cmp_valid_in && en && !wide_operand_select_in && !psel_in;
  endsequence
  property p_res(o);
    s_go ##0 cmp_op_in == o |=> cnd[$past(sh)+:4] == $past(e);
  endproperty
  a_signed_reg: assert property (p_res(2'h0))
    else $error("signed register result wrong");
  a_signed_imm: assert property (p_res(2'h1))
    else $error("signed immediate result wrong");
  a_unsigned_reg: assert property (p_res(2'h2))
    else $error("unsigned register result wrong");
  a_unsigned_imm: assert property (p_res(2'h3))
    else $error("unsigned immediate result wrong");
  a_done_pulse: assert property (s_go |=> cmp_done_out && !cmp_invalid_out)
    else $error("done pulse missing");
  a_wide_refused: assert property (cmp_valid_in && en && wide_operand_select_in && !psel_in
    |=> cmp_invalid_out && !cmp_done_out && $stable(cnd))
    else $error("wide form not refused");
  a_others_kept: assert property (s_go |=> ((cnd ^ $past(cnd)) & ~(32'h0000_000F << $past(sh))) == 0)
    else $error("other field changed");
  a_equal_bit: assert property (s_go ##0 e[2] |=> cnd[$past(sh) + 2])
    else $error("equal bit misplaced");
  a_overflow_copy: assert property (s_go ##0 !cmp_op_in[1] |=> cnd[$past(sh) + 3] == $past(e[3]))
    else $error("overflow copy wrong");
endmodule
bind integer_compare_unit cmp_checker cmp_checker_inst (.*);

// ### tb/gpr_issue.sv
`timescale 1ns/10ps
module gpr_issue (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic go_in,
  input wire logic [86:0] req_in,
  output logic valid_out,
  output logic [86:0] req_out
);
  // Idle operands flip every cycle so a stale value can never pass as a request.
  always @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      valid_out <= 1'b0;
      req_out <= 87'h0;
    end
    else
    begin
      valid_out <= go_in;
      req_out <= go_in ? req_in : ~req_out;
    end
endmodule

// ### tb/integer_compare_unit_tb.sv
`timescale 1ns/10ps
module integer_compare_unit_tb;
  logic sys_clk_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, go;
  logic cmp_valid_in, wide_operand_select_in, summary_overflow_in, cmp_done_out, cmp_invalid_out;
  logic [1:0] cmp_op_in;
  logic [2:0] target_condition_field_in;
  logic [11:0] paddr_in;
  logic [15:0] immediate_in;
  logic [31:0] pwdata_in, prdata_out, condition_bits_register_out, cexp, rs, a, t;
  logic [2:0] last_f;
  logic [31:0] source_gpr_one_in, source_gpr_two_in;
  logic [86:0] rq, pr;
  logic [32:0] qc[$], qr[$];
  int fails, n_compared, n_cmp;
  integer_compare_unit integer_compare_unit_inst (.*);
  gpr_issue gpr_issue_inst (.sys_clk_in, .nrst_in, .go_in(go), .req_in(rq),
    .valid_out(cmp_valid_in), .req_out(pr));
  assign {cmp_op_in, target_condition_field_in, wide_operand_select_in, summary_overflow_in,
    source_gpr_one_in, source_gpr_two_in, immediate_in} = pr;
  task chk(input [32:0] s, input [32:0] x);
    n_compared++;
    if (s !== x)
    begin
      fails++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, x);
    end
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    xs = rs;
  endfunction
  task cmp(input [1:0] o, input [2:0] f, input w, s, input [31:0] x, y, input [15:0] i);
    logic [31:0] b;
    @(posedge sys_clk_in);
    go <= 1'b1;
    rq <= {o, f, w, s, x, y, i};
    b = o[0] ? (o[1] ? {16'h0000, i} : {{16{i[15]}}, i}) : y;
    if (!w)
    begin
      cexp[4 * f +: 4] = o[1] ? {s, x == b, x > b, x < b}
        : {s, x == b, $signed(x) > $signed(b), $signed(x) < $signed(b)};
      n_cmp++;
      last_f = f;
    end
    qc.push_back({w, cexp});
  endtask
  task apb(input w, input [11:0] ad, input [31:0] d, input [32:0] x);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= ad;
    pwdata_in <= d;
    qr.push_back(x);
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    @(posedge sys_clk_in);
    while (pready_out !== 1'b1) @(posedge sys_clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  always @(posedge sys_clk_in)
    if (nrst_in)
    begin
      if ((cmp_done_out | cmp_invalid_out) === 1'b1)
        chk({cmp_invalid_out, condition_bits_register_out}, qc.pop_front());
      if (pready_out === 1'b1)
        chk({pslverr_out, pwrite_in ? 32'h0000_0000 : prdata_out}, qr.pop_front());
    end
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    fails++;
    close_out;
  end
  initial
  begin
    {nrst_in, psel_in, penable_in, pwrite_in, go, paddr_in, pwdata_in, rq, cexp, last_f} = 0;
    {fails, n_compared, n_cmp} = 0;
    rs = 32'h0000_366F;
    repeat (20) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000, 33'h0);
    cmp(2'h0, 3'h7, 1'b0, 1'b1, 32'h8000_0000, 32'h7FFF_FFFF, 16'h0000);
    cmp(2'h2, 3'h7, 1'b0, 1'b0, 32'h8000_0000, 32'h7FFF_FFFF, 16'h0000);
    cmp(2'h1, 3'h0, 1'b0, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 16'hFFFF);
    cmp(2'h3, 3'h1, 1'b0, 1'b0, 32'h0000_FFFF, 32'h0000_0000, 16'hFFFF);
    cmp(2'h0, 3'h2, 1'b1, 1'b1, 32'h0000_0001, 32'h0000_0002, 16'h0000);
    for (int k = 0; k < 128; k++)
    begin
      a = xs();
      t = xs();
      cmp(k[1:0], k[4:2], k % 7 == 6, k[5], a, k[3] ? a : t, k[6] ? a[15:0] : t[15:0]);
    end
    @(posedge sys_clk_in);
    go <= 1'b0;
    apb(1'b0, 12'h000, 32'h0000_0000, {1'b0, cexp});
    apb(1'b1, 12'h000, 32'hA5A5_0F0F, 33'h0);
    cexp = 32'hA5A5_0F0F;
    cmp(2'h2, 3'h3, 1'b0, 1'b1, 32'h0000_0005, 32'h0000_0009, 16'h0000);
    @(posedge sys_clk_in);
    go <= 1'b0;
    apb(1'b0, 12'h000, 32'h0000_0000, {1'b0, cexp});
    apb(1'b0, 12'h010, 32'h0000_0000, 33'h1_0000_0000);
    apb(1'b1, 12'hFFC, 32'h1234_5678, 33'h1_0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000, {1'b0, n_cmp});
    apb(1'b0, 12'h008, 32'h0000_0000, {26'h0, last_f, 4'h3});
    apb(1'b1, 12'h008, 32'h0000_0003, 33'h0);
    apb(1'b1, 12'h00C, 32'h0000_0000, 33'h0);
    apb(1'b0, 12'h004, 32'h0000_0000, 33'h1);
    apb(1'b1, 12'h004, 32'h0000_0000, 33'h0);
    // A disabled unit must stay silent, so the note just queued is withdrawn.
    cmp(2'h0, 3'h5, 1'b1, 1'b0, 32'h0000_0001, 32'h0000_0002, 16'h0000);
    void'(qc.pop_back());
    @(posedge sys_clk_in);
    go <= 1'b0;
    apb(1'b0, 12'h008, 32'h0000_0000, {26'h0, last_f, 4'h0});
    apb(1'b0, 12'h00C, 32'h0000_0000, 33'h0);
    apb(1'b0, 12'h000, 32'h0000_0000, {1'b0, cexp});
    repeat (4) @(posedge sys_clk_in);
    chk(33'(qc.size()), 33'h0);
    chk(33'(qr.size()), 33'h0);
    close_out;
  end
endmodule
